// [verilog/bcfrf_pkg.sv]
// constants, types and mapping functions of the banked register file
package bcfrf_pkg;

	// ********************************************************
	// sizes and reset values
	// ********************************************************
	localparam int WORD_W = 32;
	localparam int GP_WORDS = 24;
	localparam int GP_LOW = 8;
	localparam int FP_WORDS = 32;
	localparam int FP_VIEWS = 16;
	localparam logic RST_MODE = 1'h1;
	localparam logic RST_BANK = 1'h1;
	localparam logic RST_SWAP = 1'h0;
	localparam logic [4:0] GP_BANK1_BASE = 5'h08;
	localparam logic [4:0] GP_UPPER_BASE = 5'h10;

	// ********************************************************
	// carriers
	// ********************************************************
	typedef enum logic [3:0] {
		FPW_SGL = 4'h1,
		FPW_XSGL = 4'h2,
		FPW_PAIR = 4'h4,
		FPW_XPAIR = 4'h8
	} bcfrf_fpw_e;

	typedef struct packed {
		logic st_we;
		logic st_mode;
		logic st_bank;
		logic fp_we;
		logic fp_swap;
		logic exc;
	} bcfrf_ctrl_s;

	typedef struct packed {
		logic [3:0] idx_a;
		logic [3:0] idx_b;
		logic we;
		logic [3:0] wr_idx;
		logic [31:0] wr_data;
	} bcfrf_gp_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] idx;
		logic [31:0] data;
	} bcfrf_ctl_s;

	typedef struct packed {
		logic we;
		bcfrf_fpw_e kind;
		logic [3:0] idx;
		logic [63:0] data;
	} bcfrf_fpwr_s;

	typedef struct packed {
		logic [3:0] sgl_idx;
		logic [3:0] pair_idx;
		logic [3:0] vec_idx;
		logic [3:0] ext_idx;
		logic [3:0] xpair_idx;
	} bcfrf_fprd_s;

	// ********************************************************
	// mapping functions
	// ********************************************************
	// architectural general index to storage slot
	function automatic logic [4:0] gp_phys(input logic [3:0] idx,
		input logic use_bank1);
		logic [4:0] r;
		r = 5'h00;
		if (idx[3]) begin
			r = GP_UPPER_BASE + {2'h0, idx[2:0]};
		end else if (use_bank1) begin
			r = GP_BANK1_BASE + {2'h0, idx[2:0]};
		end else begin
			r = {2'h0, idx[2:0]};
		end
		return r;
	endfunction

	// floating view index to storage slot, bank in the top bit
	function automatic logic [4:0] fp_phys(input logic [3:0] idx,
		input logic ext, input logic swap);
		return {ext ^ swap, idx};
	endfunction

endpackage

// [verilog/bcfrf_gpr_store.sv]
// storage of the twenty-four general words
`timescale 1ns/100ps
`default_nettype none
module bcfrf_gpr_store #(
	parameter int WORDS = 24
) (
	input wire logic clk,
	input wire logic [4:0] rd_a_idx,
	input wire logic [4:0] rd_b_idx,
	input wire logic [4:0] rd_c_idx,
	output logic [31:0] rd_a,
	output logic [31:0] rd_b,
	output logic [31:0] rd_c,
	input wire logic wr_a_en,
	input wire logic [4:0] wr_a_idx,
	input wire logic [31:0] wr_a_data,
	input wire logic wr_b_en,
	input wire logic [4:0] wr_b_idx,
	input wire logic [31:0] wr_b_data
);
	logic [31:0] mem [WORDS];

	initial begin
		if (WORDS != 24) $error("general store must hold 24 words");
	end

	// port a wins over port b on the same slot
	always_ff @(posedge clk) begin
		if (wr_b_en && !(wr_a_en && wr_a_idx == wr_b_idx)) begin
			mem[wr_b_idx] <= wr_b_data;
		end
		if (wr_a_en) begin
			mem[wr_a_idx] <= wr_a_data;
		end
	end

	// combinational reads, registered by the caller
	assign rd_a = mem[rd_a_idx];
	assign rd_b = mem[rd_b_idx];
	assign rd_c = mem[rd_c_idx];
endmodule
`default_nettype wire

// [verilog/bcfrf_fpr_store.sv]
// storage of the thirty-two floating words, two banks of sixteen
`timescale 1ns/100ps
`default_nettype none
module bcfrf_fpr_store #(
	parameter int WORDS = 32
) (
	input wire logic clk,
	input wire logic [1:0] wr_en,
	input wire logic [4:0] wr_idx,
	input wire logic [63:0] wr_data,
	output logic [WORDS*32-1:0] all_words
);
	logic [31:0] mem [WORDS];
	logic [4:0] idx_hi;

	initial begin
		if (WORDS != 32) $error("floating store must hold 32 words");
	end

	// lane 1 is the second word of a pair
	assign idx_hi = wr_idx + 5'h01;

	// lane 0 takes the upper half, the first element of a pair
	always_ff @(posedge clk) begin
		if (wr_en[0]) begin
			mem[wr_idx] <= wr_data[63:32];
		end
		if (wr_en[1]) begin
			mem[idx_hi] <= wr_data[31:0];
		end
	end

	// flat view, slot k in bits 32k+31..32k
	always_comb begin
		for (int k = 0; k < WORDS; k++) begin
			all_words[k*32 +: 32] = mem[k];
		end
	end
endmodule
`default_nettype wire

// [verilog/bcfrf_top.sv]
// banked general and floating register file of the core
// How it works
// RULE_01: 24 general words, sixteen visible at once
// RULE_02: user mode maps low registers to bank zero
// RULE_03: privileged, select clear: bank zero mapped
// RULE_04: privileged, select set: bank one mapped
// RULE_05: other bank via control load/store only
// RULE_06: 32 floating words in two banks
// RULE_07: single views follow swap bit bank
// RULE_08: extended views use the opposite bank
// RULE_09: pair view joins single n, n+1
// RULE_10: vector view joins four single views
// RULE_11: extended pair joins extended n, n+1
// RULE_12: matrix is sixteen extended, column order
// RULE_13: reset sets privilege and bank select
// RULE_14: exception or interrupt forces bank one; CTRL.exc sets only the bank select, so user mode stays on bank zero
// RULE_15: upper eight registers shared by all modes
// RULE_16: bit changes apply to following accesses
`timescale 1ns/100ps
`default_nettype none
module bcfrf_top (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire bcfrf_pkg::bcfrf_ctrl_s CTRL,
	input wire bcfrf_pkg::bcfrf_gp_s GP,
	input wire bcfrf_pkg::bcfrf_ctl_s CTL,
	input wire bcfrf_pkg::bcfrf_fpwr_s FPWR,
	input wire bcfrf_pkg::bcfrf_fprd_s FPRD,
	output logic [31:0] GP_RD_A,
	output logic [31:0] GP_RD_B,
	output logic [31:0] CTL_RD_DATA,
	output logic CTL_FAULT,
	output logic [31:0] FP_SGL_RD,
	output logic [63:0] FP_PAIR_RD,
	output logic [127:0] FP_VEC_RD,
	output logic [31:0] FP_EXT_RD,
	output logic [63:0] FP_XPAIR_RD,
	output logic [511:0] FP_MTRX_RD,
	output logic PRIV_MODE,
	output logic BANK_SEL,
	output logic FP_SWAP
);
	import bcfrf_pkg::*;

	// ********************************************************
	// mode bits
	// ********************************************************
	logic privilege_mode_bit_r;
	logic register_bank_select_r;
	logic fp_bank_swap_bit_r;
	logic use_bank1;

	// status word bits; exception forces the bank select
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			privilege_mode_bit_r <= RST_MODE; // RULE_13
			register_bank_select_r <= RST_BANK; // RULE_13
		end else begin
			if (CTRL.st_we) begin
				privilege_mode_bit_r <= CTRL.st_mode; // RULE_16
				register_bank_select_r <= CTRL.st_bank;
			end
			if (CTRL.exc) begin
				register_bank_select_r <= 1'h1; // RULE_14
			end
		end
	end

	// floating bank swap bit of the control word
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			fp_bank_swap_bit_r <= RST_SWAP;
		end else if (CTRL.fp_we) begin
			fp_bank_swap_bit_r <= CTRL.fp_swap; // RULE_16
		end
	end

	// bank one only when privileged with select set
	assign use_bank1 = privilege_mode_bit_r
		& register_bank_select_r; // RULE_02 RULE_03 RULE_04

	// ********************************************************
	// general registers
	// ********************************************************
	logic [4:0] pa_idx;
	logic [4:0] pb_idx;
	logic [4:0] pw_idx;
	logic [4:0] ctl_idx;
	logic ctl_ok;
	logic [31:0] gp_a;
	logic [31:0] gp_b;
	logic [31:0] gp_c;

	// architectural to slot, upper eight map to one copy
	assign pa_idx = gp_phys(GP.idx_a, use_bank1); // RULE_01 RULE_15
	assign pb_idx = gp_phys(GP.idx_b, use_bank1);
	assign pw_idx = gp_phys(GP.wr_idx, use_bank1);
	// control access names the bank that is not mapped
	assign ctl_idx = gp_phys({1'h0, CTL.idx}, ~use_bank1); // RULE_05
	assign ctl_ok = privilege_mode_bit_r; // RULE_05

	bcfrf_gpr_store #(
		.WORDS(GP_WORDS)
	) u_gpr (
		.clk(REF_CLK),
		.rd_a_idx(pa_idx),
		.rd_b_idx(pb_idx),
		.rd_c_idx(ctl_idx),
		.rd_a(gp_a),
		.rd_b(gp_b),
		.rd_c(gp_c),
		.wr_a_en(GP.we),
		.wr_a_idx(pw_idx),
		.wr_a_data(GP.wr_data),
		.wr_b_en(CTL.wr & ctl_ok), // RULE_02
		.wr_b_idx(ctl_idx),
		.wr_b_data(CTL.data)
	);

	// registered general read ports
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			GP_RD_A <= 32'h0;
			GP_RD_B <= 32'h0;
		end else begin
			GP_RD_A <= gp_a;
			GP_RD_B <= gp_b;
		end
	end

	// control access: data when privileged, fault pulse in user mode
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			CTL_RD_DATA <= 32'h0;
			CTL_FAULT <= 1'h0;
		end else begin
			CTL_FAULT <= (CTL.rd | CTL.wr) & ~ctl_ok; // RULE_02
			if (CTL.rd && ctl_ok) begin
				CTL_RD_DATA <= gp_c; // RULE_05
			end
		end
	end

	// ********************************************************
	// floating registers
	// ********************************************************
	logic [FP_WORDS*32-1:0] fp_all;
	logic [31:0] fr [FP_VIEWS];
	logic [31:0] xf [FP_VIEWS];
	logic [1:0] fw_en;
	logic [4:0] fw_idx;

	// view tables over the flat store
	always_comb begin
		for (int i = 0; i < FP_VIEWS; i++) begin
			fr[i] = fp_all[32*fp_phys(4'(i), 1'h0,
				fp_bank_swap_bit_r) +: 32]; // RULE_07
			xf[i] = fp_all[32*fp_phys(4'(i), 1'h1,
				fp_bank_swap_bit_r) +: 32]; // RULE_08
		end
	end

	// write decode: single words on lane 0, pairs on both lanes
	always_comb begin
		fw_en = 2'h0;
		fw_idx = fp_phys(FPWR.idx, 1'h0, fp_bank_swap_bit_r);
		if (FPWR.we) begin
			case (FPWR.kind)
				FPW_SGL: begin
					fw_en = 2'h1;
				end
				FPW_XSGL: begin
					fw_en = 2'h1;
					fw_idx = fp_phys(FPWR.idx, 1'h1, fp_bank_swap_bit_r);
				end
				FPW_PAIR: begin
					fw_en = 2'h3; // RULE_09
					fw_idx = fp_phys({FPWR.idx[3:1], 1'h0}, 1'h0,
						fp_bank_swap_bit_r);
				end
				FPW_XPAIR: begin
					fw_en = 2'h3; // RULE_11
					fw_idx = fp_phys({FPWR.idx[3:1], 1'h0}, 1'h1,
						fp_bank_swap_bit_r);
				end
				default: begin
					fw_en = 2'h0;
				end
			endcase
		end
	end

	bcfrf_fpr_store #(
		.WORDS(FP_WORDS)
	) u_fpr (
		.clk(REF_CLK),
		.wr_en(fw_en),
		.wr_idx(fw_idx),
		.wr_data(FPWR.data),
		.all_words(fp_all)
	); // RULE_06

	logic [3:0] pr_i;
	logic [3:0] vr_i;
	logic [3:0] xp_i;
	assign pr_i = {FPRD.pair_idx[3:1], 1'h0};
	assign vr_i = {FPRD.vec_idx[3:2], 2'h0};
	assign xp_i = {FPRD.xpair_idx[3:1], 1'h0};

	// registered floating views, first element in the upper bits
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			FP_SGL_RD <= 32'h0;
			FP_PAIR_RD <= 64'h0;
			FP_VEC_RD <= 128'h0;
			FP_EXT_RD <= 32'h0;
			FP_XPAIR_RD <= 64'h0;
		end else begin
			FP_SGL_RD <= fr[FPRD.sgl_idx];
			FP_PAIR_RD <= {fr[pr_i], fr[pr_i + 4'h1]}; // RULE_09
			FP_VEC_RD <= {fr[vr_i], fr[vr_i + 4'h1], fr[vr_i + 4'h2],
				fr[vr_i + 4'h3]}; // RULE_10
			FP_EXT_RD <= xf[FPRD.ext_idx];
			FP_XPAIR_RD <= {xf[xp_i], xf[xp_i + 4'h1]}; // RULE_11
		end
	end

	// matrix: extended view k at bits 511-32k, columns of four
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			FP_MTRX_RD <= 512'h0;
		end else begin
			for (int k = 0; k < FP_VIEWS; k++) begin
				FP_MTRX_RD[511-32*k -: 32] <= xf[k]; // RULE_12
			end
		end
	end

	// mode bits seen outside
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			PRIV_MODE <= RST_MODE;
			BANK_SEL <= RST_BANK;
			FP_SWAP <= RST_SWAP;
		end else begin
			PRIV_MODE <= privilege_mode_bit_r;
			BANK_SEL <= register_bank_select_r;
			FP_SWAP <= fp_bank_swap_bit_r;
		end
	end

	// ********************************************************
	// checks
	// ********************************************************
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RSTN);

	sequence s_exc;
		CTRL.exc;
	endsequence
	sequence s_bank_one;
		register_bank_select_r ##1 BANK_SEL;
	endsequence

	property p_reset_bits;
		@(posedge REF_CLK) disable iff (1'b0)
		!RSTN |=> privilege_mode_bit_r && register_bank_select_r;
	endproperty

	a_reset_mode_bank: assert property (p_reset_bits) // RULE_13
		else $error("reset did not set mode and bank");
	a_exc_bank_one: assert property (s_exc |=> s_bank_one) // RULE_14
		else $error("exception did not select bank one");
	a_user_low_bank: assert property (!privilege_mode_bit_r
		&& !GP.idx_a[3] |-> pa_idx < GP_BANK1_BASE) // RULE_02
		else $error("user access reached bank one");
	a_priv_bank_zero: assert property (privilege_mode_bit_r
		&& !register_bank_select_r && !GP.idx_b[3]
		|-> pb_idx == {2'h0, GP.idx_b[2:0]}) // RULE_03
		else $error("privileged select clear not bank zero");
	a_priv_bank_one: assert property (use_bank1 && !GP.idx_a[3]
		|-> pa_idx == GP_BANK1_BASE + {2'h0, GP.idx_a[2:0]}) // RULE_04
		else $error("privileged select set not bank one");
	a_upper_shared: assert property (GP.idx_a[3]
		|-> pa_idx == GP_UPPER_BASE + {2'h0, GP.idx_a[2:0]}) // RULE_15
		else $error("upper register not shared");
	a_ctl_user_fault: assert property ((CTL.rd || CTL.wr)
		&& !privilege_mode_bit_r |=> CTL_FAULT ##1 !CTL_FAULT
		|| $past(CTL.rd || CTL.wr, 1)) // RULE_05
		else $error("user control access not refused");
	a_status_apply: assert property (CTRL.st_we && !CTRL.exc
		|=> privilege_mode_bit_r == $past(CTRL.st_mode)
		&& register_bank_select_r == $past(CTRL.st_bank)) // RULE_16
		else $error("status write not applied next cycle");
	// storage starts undefined, so views compare by case equality
	a_ext_opposite: assert property (1'h1 |=> FP_EXT_RD === $past(
		fp_all[32*{~fp_bank_swap_bit_r, FPRD.ext_idx} +: 32])) // RULE_08
		else $error("extended view not opposite bank");
	a_pair_head: assert property (1'h1 |=> FP_PAIR_RD[63:32]
		=== $past(fr[pr_i])) // RULE_09
		else $error("pair view first element wrong");
	a_fault_priv_quiet: assert property (privilege_mode_bit_r
		|=> !CTL_FAULT) // RULE_05
		else $error("privileged control access faulted");
	a_swap_apply: assert property (CTRL.fp_we
		|=> fp_bank_swap_bit_r == $past(CTRL.fp_swap)) // RULE_16
		else $error("swap write not applied next cycle");
endmodule
`default_nettype wire

// [test/bcfrf_dp_model.sv]
// datapath model issuing register file accesses on the clock
`timescale 1ns/100ps
`default_nettype none
module bcfrf_dp_model (
	input wire logic clk,
	output var bcfrf_pkg::bcfrf_ctrl_s ctrl,
	output var bcfrf_pkg::bcfrf_gp_s gp,
	output var bcfrf_pkg::bcfrf_ctl_s ctl,
	output var bcfrf_pkg::bcfrf_fpwr_s fpwr,
	output var bcfrf_pkg::bcfrf_fprd_s fprd
);
	import bcfrf_pkg::*;

	// all pulses low and indices zero before the first access
	initial begin
		ctrl = '0;
		gp = '0;
		ctl = '0;
		fpwr = '0;
		fprd = '0;
	end

	// sampling edge: drop the pulses, then let outputs settle
	task automatic step();
		@(posedge clk);
		ctrl.st_we <= 1'b0;
		ctrl.fp_we <= 1'b0;
		ctrl.exc <= 1'b0;
		gp.we <= 1'b0;
		ctl.rd <= 1'b0;
		ctl.wr <= 1'b0;
		fpwr.we <= 1'b0;
		#1;
	endtask

	task automatic mode_wr(input logic m, input logic b);
		@(posedge clk);
		ctrl.st_we <= 1'b1;
		ctrl.st_mode <= m;
		ctrl.st_bank <= b;
		step();
	endtask

	task automatic swap_wr(input logic s);
		@(posedge clk);
		ctrl.fp_we <= 1'b1;
		ctrl.fp_swap <= s;
		step();
	endtask

	task automatic exc_pulse();
		@(posedge clk);
		ctrl.exc <= 1'b1;
		step();
	endtask

	task automatic gp_wr(input logic [3:0] i, input logic [31:0] d);
		@(posedge clk);
		gp.we <= 1'b1;
		gp.wr_idx <= i;
		gp.wr_data <= d;
		step();
	endtask

	task automatic gp_rd(input logic [3:0] a, input logic [3:0] b);
		@(posedge clk);
		gp.idx_a <= a;
		gp.idx_b <= b;
		step();
	endtask

	// control load or store on the bank that is not mapped
	task automatic ctl_op(input logic r, input logic w,
		input logic [2:0] i, input logic [31:0] d);
		@(posedge clk);
		ctl <= {r, w, i, d};
		step();
	endtask

	task automatic fp_wr(input bcfrf_fpw_e k, input logic [3:0] i,
		input logic [63:0] d);
		@(posedge clk);
		fpwr <= {1'b1, k, i, d};
		step();
	endtask

	task automatic fp_rd(input logic [3:0] i);
		@(posedge clk);
		fprd <= {i, i, i, i, i};
		step();
	endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench of the banked register file
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import bcfrf_pkg::*;

	logic ref_clk;
	logic rstn;
	bcfrf_ctrl_s ctrl;
	bcfrf_gp_s gp;
	bcfrf_ctl_s ctl;
	bcfrf_fpwr_s fpwr;
	bcfrf_fprd_s fprd;
	logic [31:0] gp_a, gp_b, ctl_d, sgl, ext;
	logic [63:0] pair, xpair;
	logic [127:0] vec;
	logic [511:0] mtrx, mx;
	logic ctl_f, pm, bs, fp_sw;
	// shadow of storage and of the mode bits
	logic [31:0] gpm [24];
	logic [31:0] fpm [32];
	logic md, bk, sw;
	logic [31:0] cw;
	logic [3:0] vb;
	logic [31:0] seed = 32'h000018EB;
	int num_errors = 0;
	int check_count = 0;
	bcfrf_fpw_e kinds [4] = '{FPW_SGL, FPW_XSGL, FPW_PAIR, FPW_XPAIR};

	bcfrf_top dut (.REF_CLK(ref_clk), .RSTN(rstn), .CTRL(ctrl), .GP(gp),
		.CTL(ctl), .FPWR(fpwr), .FPRD(fprd), .GP_RD_A(gp_a),
		.GP_RD_B(gp_b), .CTL_RD_DATA(ctl_d), .CTL_FAULT(ctl_f),
		.FP_SGL_RD(sgl), .FP_PAIR_RD(pair), .FP_VEC_RD(vec),
		.FP_EXT_RD(ext), .FP_XPAIR_RD(xpair), .FP_MTRX_RD(mtrx),
		.PRIV_MODE(pm), .BANK_SEL(bs), .FP_SWAP(fp_sw));

	bcfrf_dp_model dp (.clk(ref_clk), .ctrl(ctrl), .gp(gp), .ctl(ctl),
		.fpwr(fpwr), .fprd(fprd));

	// xorshift source of data words
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// storage slot of a general register under the shadow mode bits
	function automatic int gsl(input logic [3:0] i);
		if (i[3]) begin
			return 16 + i[2:0];
		end
		return (md && bk) ? 8 + i[2:0] : i[2:0];
	endfunction

	// single (x=0) or extended (x=1) view under the shadow swap bit
	function automatic logic [31:0] fv(input logic [3:0] i, input logic x);
		return fpm[{x ^ sw, i}];
	endfunction

	task automatic check(input logic [511:0] seen, input logic [511:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic set_mode(input logic m, input logic b);
		dp.mode_wr(m, b);
		md = m;
		bk = b;
	endtask

	task automatic gw(input logic [3:0] i);
		logic [31:0] d;
		d = rnd();
		gpm[gsl(i)] = d;
		dp.gp_wr(i, d);
	endtask

	task automatic fw(input bcfrf_fpw_e k, input logic [3:0] i);
		logic [63:0] d;
		logic x;
		d = {rnd(), rnd()};
		x = (k == FPW_XSGL || k == FPW_XPAIR);
		if (k == FPW_SGL || k == FPW_XSGL) begin
			fpm[{x ^ sw, i}] = d[63:32];
		end else begin
			fpm[{x ^ sw, i & 4'hE}] = d[63:32];
			fpm[{x ^ sw, i | 4'h1}] = d[31:0];
		end
		dp.fp_wr(k, i, d);
	endtask

	// 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// cut a hang short
	initial begin
		#50000;
		num_errors++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		rstn = 1'b0;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		#1;
		check(pm, 1'h1);
		check(bs, 1'h1);
		check(fp_sw, 1'h0);
		md = 1'b1;
		bk = 1'b1;
		sw = 1'b0;
		// fill bank one, then bank zero, and the upper words twice
		for (int p = 0; p < 2; p++) begin
			set_mode(1'b1, ~p[0]);
			for (int i = 0; i < 16; i++) begin
				gw(i[3:0]);
			end
		end
		// read back under all four mode settings
		for (int p = 0; p < 4; p++) begin
			set_mode(p[1], p[0]);
			for (int i = 0; i < 16; i++) begin
				dp.gp_rd(i[3:0], 4'hF - i[3:0]);
				check(gp_a, gpm[gsl(i[3:0])]);
				check(gp_b, gpm[gsl(4'hF - i[3:0])]);
			end
			check(pm, md);
			check(bs, bk);
		end
		// control store and load reach only the unmapped bank
		for (int p = 0; p < 2; p++) begin
			set_mode(1'b1, p[0]);
			for (int i = 0; i < 8; i++) begin
				cw = rnd();
				dp.ctl_op(1'b0, 1'b1, i[2:0], cw);
				gpm[(bk ? 0 : 8) + i] = cw;
				dp.ctl_op(1'b1, 1'b0, i[2:0], 32'h0);
				check(ctl_d, cw);
				check(ctl_f, 1'h0);
				dp.gp_rd(i[3:0], i[3:0]);
				check(gp_a, gpm[gsl(i[3:0])]);
			end
		end
		// user mode: control access refused, data held
		set_mode(1'b0, 1'b0);
		dp.ctl_op(1'b0, 1'b1, 3'h2, rnd());
		check(ctl_f, 1'h1);
		dp.ctl_op(1'b1, 1'b0, 3'h2, 32'h0);
		check(ctl_f, 1'h1);
		check(ctl_d, gpm[7]);
		// exception forces bank one; the refused store left it intact
		set_mode(1'b1, 1'b0);
		dp.exc_pulse();
		bk = 1'b1;
		dp.gp_rd(4'h2, 4'hA);
		check(bs, 1'h1);
		check(pm, 1'h1);
		check(gp_a, gpm[gsl(4'h2)]);
		// floating writes of every kind, then one invalid kind
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 16; i++) begin
				fw(kinds[k], i[3:0]);
			end
		end
		dp.fp_wr(bcfrf_fpw_e'(4'h3), 4'h0, {rnd(), rnd()});
		// every view under both swap settings
		for (int s = 0; s < 2; s++) begin
			dp.swap_wr(s[0]);
			sw = s[0];
			for (int i = 0; i < 16; i++) begin
				dp.fp_rd(i[3:0]);
				vb = i[3:0] & 4'hC;
				check(sgl, fv(i[3:0], 1'b0));
				check(ext, fv(i[3:0], 1'b1));
				check(pair, {fv(i[3:0] & 4'hE, 1'b0),
					fv(i[3:0] | 4'h1, 1'b0)});
				check(xpair, {fv(i[3:0] & 4'hE, 1'b1),
					fv(i[3:0] | 4'h1, 1'b1)});
				check(vec, {fv(vb, 1'b0), fv(vb + 4'h1, 1'b0),
					fv(vb + 4'h2, 1'b0), fv(vb + 4'h3, 1'b0)});
			end
			for (int k = 0; k < 16; k++) begin
				mx[511 - 32 * k -: 32] = fv(k[3:0], 1'b1);
			end
			check(mtrx, mx);
			check(fp_sw, sw);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
